// *** relay_servant_pkg.sv ***
// package for the word serial relay servant: register map, command codes, fixed words
// assumes A16/D16 backplane signals are already decoded to plain strobes
package relay_servant_pkg;

  // ---------------------------------------------
  // register offsets within the 64-byte block
  // ---------------------------------------------
  localparam logic [5:0] OFS_IDENTITY = 6'h00;
  localparam logic [5:0] OFS_MODEL = 6'h02;
  localparam logic [5:0] OFS_STATUS_CTRL = 6'h04;
  localparam logic [5:0] OFS_UNUSED = 6'h06;
  localparam logic [5:0] OFS_PROTOCOL = 6'h08;
  localparam logic [5:0] OFS_RESPONSE = 6'h0A;
  localparam logic [5:0] OFS_DATA_LOW_WR = 6'h0C;
  localparam logic [5:0] OFS_DATA_LOW_RD = 6'h0E;

  // ---------------------------------------------
  // address decode constants
  // ---------------------------------------------
  localparam logic [15:0] SHORT_BASE = 16'hC000;
  localparam logic [15:0] BLOCK_STRIDE = 16'h0040;
  localparam logic [5:0] ADDR_MOD_A16_SUP = 6'h2D;
  localparam logic [5:0] ADDR_MOD_A16_USR = 6'h29;

  // ---------------------------------------------
  // fixed words
  // ---------------------------------------------
  localparam logic [15:0] PROTOCOL_WORD = 16'hEFFF;
  localparam logic [15:0] READ_PROTOCOL_ANSWER = 16'hFF6B;
  localparam logic [15:0] STATUS_FIXED = 16'h3FF3;
  localparam logic [15:0] RESPONSE_FIXED = 16'h4000;
  localparam int RESP_WRITE_READY_BIT = 9;
  localparam int RESP_READ_READY_BIT = 10;
  localparam int RESP_DOR_BIT = 13;
  localparam int STATUS_READY_BIT = 3;
  localparam int STATUS_PASSED_BIT = 2;
  localparam int STATUS_A24_BIT = 14;
  localparam int CTRL_SYSFAIL_INH_BIT = 1;
  localparam int CTRL_RESET_BIT = 0;

  // ---------------------------------------------
  // word serial commands (upper byte or full word)
  // ---------------------------------------------
  localparam logic [7:0] WS_BYTE_AVAIL = 8'hBC;
  localparam logic [7:0] WS_BYTE_AVAIL_END = 8'hBD;
  localparam logic [15:0] WS_BYTE_REQUEST = 16'hDEFF;
  localparam logic [15:0] WS_READ_PROTOCOL = 16'hCFFF;

  // ---------------------------------------------
  // ascii
  // ---------------------------------------------
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_O = 8'h4F;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_Q = 8'h51;
  localparam logic [4:0] RELAY_MAX = 5'd31;

  typedef enum logic [2:0] {P_IDLE, P_DIG1, P_DIG2} parse_type;

endpackage : relay_servant_pkg

// *** relay_servant.sv ***
// relay servant: A16/D16 register block, word serial byte transfer, ascii relay parser
// assumes address, modifier and strobes come from backplane pins on a foreign clock,
// and that iack cycles are qualified by the backplane interface into i_iack_n
module relay_servant
  import relay_servant_pkg::*;
#(
  parameter logic [15:0] ID_WORD = 16'h1234, // arbitrary value
  parameter logic [15:0] MODEL_WORD = 16'h5678, // arbitrary value
  parameter int RELAYS = 32
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // backplane slave, from pins
  input wire logic [15:0] i_addr,
  input wire logic [5:0] i_am,
  input wire logic i_strobe_n,
  input wire logic i_write_n,
  input wire logic i_iack_n,
  input wire logic [15:0] i_wdata,
  input wire logic [7:0] i_logical_addr,
  // read data and acknowledge
  output logic [15:0] o_rdata,
  output logic o_rdata_oe,
  output logic o_dtack_n,
  // relay drive and end flag seen with last response byte
  output logic [RELAYS-1:0] o_relay_closed,
  output logic o_end_flag
);

  // ---------------------------------------------
  // pin synchronisers
  // ---------------------------------------------
  logic [1:0] strb_sync_reg, wr_sync_reg, iack_sync_reg;
  logic strb_d_reg;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      strb_sync_reg <= 2'h3;
      wr_sync_reg <= 2'h3;
      iack_sync_reg <= 2'h3;
      strb_d_reg <= 1'b1;
    end else begin
      strb_sync_reg <= {strb_sync_reg[0], i_strobe_n};
      wr_sync_reg <= {wr_sync_reg[0], i_write_n};
      iack_sync_reg <= {iack_sync_reg[0], i_iack_n};
      strb_d_reg <= strb_sync_reg[1];
    end
  end
  // address and data are stable while strobe is low, so they are read after the strobe sync
  wire strobe_start = strb_d_reg && !strb_sync_reg[1];
  wire strobe_low = !strb_sync_reg[1];

  // ---------------------------------------------
  // address decode
  // ---------------------------------------------
  wire [15:0] base_addr = SHORT_BASE + {2'b00, i_logical_addr, 6'h00};
  wire short_space = (i_am == ADDR_MOD_A16_SUP) || (i_am == ADDR_MOD_A16_USR);
  wire in_block = (i_addr[15:6] == base_addr[15:6]);
  wire [5:0] ofs = i_addr[5:0];
  wire hit = short_space && in_block && iack_sync_reg[1];
  wire iack_hit = !iack_sync_reg[1];
  wire is_wr = !wr_sync_reg[1];
  wire wr_ctrl = strobe_start && hit && is_wr && (ofs == OFS_STATUS_CTRL);
  wire wr_data = strobe_start && hit && is_wr && (ofs == OFS_DATA_LOW_WR);
  wire rd_data = strobe_start && hit && !is_wr && (ofs == OFS_DATA_LOW_RD);

  // ---------------------------------------------
  // word serial state
  // ---------------------------------------------
  logic write_ready_reg, read_ready_reg, busy_reg, end_flag_reg;
  logic [15:0] rx_word_reg, data_low_reg;
  logic [1:0] ctrl_reg;
  logic [1:0] resp_left_reg;
  logic resp_pending_reg;

  wire [7:0] cmd_hi = rx_word_reg[15:8];
  wire [7:0] cmd_lo = rx_word_reg[7:0];
  wire byte_avail = (cmd_hi == WS_BYTE_AVAIL) || (cmd_hi == WS_BYTE_AVAIL_END);
  wire byte_req = (rx_word_reg == WS_BYTE_REQUEST);
  wire read_proto = (rx_word_reg == WS_READ_PROTOCOL);

  // ---------------------------------------------
  // ascii parser
  // ---------------------------------------------
  parse_type pstate_reg;
  logic [7:0] pcmd_reg;
  logic [3:0] tens_reg;
  logic [4:0] query_sel_reg;
  logic [RELAYS-1:0] relay_reg;

  wire parse_now = busy_reg && byte_avail;
  wire is_digit = (cmd_lo >= CH_ZERO) && (cmd_lo <= (CH_ZERO + 8'h09));
  wire [3:0] digit = cmd_lo[3:0];
  wire [7:0] relay_num = 8'({tens_reg, 3'h0}) + 8'({tens_reg, 1'b0}) + 8'(digit);
  wire num_ok = (relay_num <= 8'(RELAY_MAX));
  wire is_letter = (cmd_lo == CH_C) || (cmd_lo == CH_O) || (cmd_lo == CH_R) || (cmd_lo == CH_Q);
  wire cmd_done = parse_now && (pstate_reg == P_DIG2) && is_digit;
  wire query_done = cmd_done && (pcmd_reg == CH_Q) && num_ok;

  // response byte sequence: status digit, cr, lf
  // relay state is read when the byte is requested, not when the query is parsed
  wire [7:0] status_digit = relay_reg[query_sel_reg] ? CH_ONE : CH_ZERO;
  wire [7:0] next_resp_byte = (resp_left_reg == 2'd3) ? status_digit :
                              (resp_left_reg == 2'd2) ? CH_CR : CH_LF;
  // with nothing left to send the lf repeats, so it carries the end flag too
  wire last_resp_byte = (resp_left_reg <= 2'd1);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pstate_reg <= P_IDLE;
      pcmd_reg <= 8'h00;
      tens_reg <= 4'h0;
    end else if (parse_now) begin
      case (pstate_reg)
        P_IDLE: begin
          if (is_letter) begin
            pcmd_reg <= cmd_lo;
            pstate_reg <= P_DIG1;
          end
        end
        P_DIG1: begin
          tens_reg <= digit;
          pstate_reg <= is_digit ? P_DIG2 : P_IDLE;
        end
        default: begin
          pstate_reg <= P_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      relay_reg <= '0;
      query_sel_reg <= 5'h00;
    end else if (ctrl_reg[CTRL_RESET_BIT]) begin
      relay_reg <= '0;
    end else if (cmd_done && num_ok) begin
      case (pcmd_reg)
        CH_R: relay_reg <= '0;
        CH_C: relay_reg[relay_num[4:0]] <= 1'b1;
        CH_O: relay_reg[relay_num[4:0]] <= 1'b0;
        default: query_sel_reg <= relay_num[4:0];
      endcase
    end
  end

  // ---------------------------------------------
  // handshake engine
  // ---------------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      write_ready_reg <= 1'b1;
      read_ready_reg <= 1'b0;
      busy_reg <= 1'b0;
      rx_word_reg <= 16'h0000;
      data_low_reg <= 16'h0000;
      ctrl_reg <= 2'h0;
      end_flag_reg <= 1'b0;
      resp_left_reg <= 2'd0;
      resp_pending_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= i_wdata[1:0];
      end
      if (query_done) begin
        resp_left_reg <= 2'd3;
      end
      if (wr_data && write_ready_reg) begin
        rx_word_reg <= i_wdata;
        write_ready_reg <= 1'b0;
        busy_reg <= 1'b1;
      end else if (busy_reg) begin
        busy_reg <= 1'b0;
        if (byte_req) begin
          data_low_reg <= {8'h00, next_resp_byte};
          end_flag_reg <= last_resp_byte;
          resp_pending_reg <= 1'b1;
          if (resp_left_reg != 2'd0 && !query_done) begin
            resp_left_reg <= resp_left_reg - 2'd1;
          end
          read_ready_reg <= 1'b1;
        end else if (read_proto) begin
          data_low_reg <= READ_PROTOCOL_ANSWER;
          resp_pending_reg <= 1'b1;
          read_ready_reg <= 1'b1;
        end else begin
          write_ready_reg <= 1'b1;
        end
      end else if (rd_data && resp_pending_reg) begin
        read_ready_reg <= 1'b0;
        resp_pending_reg <= 1'b0;
        write_ready_reg <= 1'b1;
      end
    end
  end

  // ---------------------------------------------
  // read mux
  // ---------------------------------------------
  wire [15:0] status_word = STATUS_FIXED | (16'(busy_reg) << STATUS_A24_BIT)
                            | (16'(write_ready_reg) << STATUS_READY_BIT)
                            | (16'h1 << STATUS_PASSED_BIT);
  wire [15:0] response_word = RESPONSE_FIXED | (16'(write_ready_reg) << RESP_WRITE_READY_BIT)
                              | (16'(read_ready_reg) << RESP_READ_READY_BIT)
                              | (16'(!resp_pending_reg) << RESP_DOR_BIT);
  wire [15:0] rd_mux = (ofs == OFS_IDENTITY) ? ID_WORD :
                       (ofs == OFS_MODEL) ? MODEL_WORD :
                       (ofs == OFS_STATUS_CTRL) ? status_word :
                       (ofs == OFS_PROTOCOL) ? PROTOCOL_WORD :
                       (ofs == OFS_RESPONSE) ? response_word :
                       (ofs == OFS_DATA_LOW_RD) ? data_low_reg : 16'h0000;

  logic [15:0] rdata_reg;
  logic oe_reg, ack_reg;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_reg <= 16'h0000;
      oe_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (!strobe_low) begin
      oe_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (strobe_start && (hit || iack_hit)) begin
      rdata_reg <= iack_hit ? {8'h00, i_logical_addr} : rd_mux;
      oe_reg <= !is_wr || iack_hit;
      ack_reg <= 1'b1;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_rdata_oe = oe_reg;
  assign o_dtack_n = !ack_reg;
  assign o_relay_closed = relay_reg;
  assign o_end_flag = end_flag_reg;

endmodule : relay_servant

// *** relay_servant_assertions.sv ***
// checker for relay_servant: acknowledge, decode and fixed register words
// assumes a bus master that holds address and strobe until acknowledge is low
module relay_servant_checker
  import relay_servant_pkg::*;
#(
  parameter int RELAYS = 32
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // backplane
  input wire logic [15:0] i_addr,
  input wire logic [5:0] i_am,
  input wire logic i_strobe_n,
  input wire logic i_write_n,
  input wire logic i_iack_n,
  input wire logic [7:0] i_logical_addr,
  // outputs
  input wire logic [15:0] o_rdata,
  input wire logic o_rdata_oe,
  input wire logic o_dtack_n,
  input wire logic [RELAYS-1:0] o_relay_closed
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire [15:0] base_w = SHORT_BASE + {2'b00, i_logical_addr, 6'h00};
  sequence s_ack;
    $fell(o_dtack_n);
  endsequence
  sequence s_rd(logic [5:0] ofs);
    !o_dtack_n && !i_strobe_n && i_write_n && i_iack_n && i_addr[5:0] == ofs;
  endsequence
  a_relays_start_open: assert property ($rose(i_nrst) |-> (o_relay_closed == '0) [*3])
    else $error("relays not open after reset");
  a_short_space_only: assert property (s_ack |-> !i_iack_n || i_am == ADDR_MOD_A16_SUP || i_am == ADDR_MOD_A16_USR)
    else $error("ack on foreign modifier");
  a_block_decode: assert property (s_ack ##0 i_iack_n |-> i_addr[15:6] == base_w[15:6])
    else $error("ack outside own block");
  a_protocol_const: assert property (s_rd(OFS_PROTOCOL) |-> o_rdata_oe && o_rdata == PROTOCOL_WORD)
    else $error("protocol word wrong");
  a_status_pattern: assert property (s_rd(OFS_STATUS_CTRL) |-> (o_rdata & 16'hBFF3) == 16'h3FF3)
    else $error("status fixed bits wrong");
  a_response_fixed: assert property (s_rd(OFS_RESPONSE) |-> (o_rdata & 16'hD9FF) == 16'h4000)
    else $error("response fixed bits wrong");
  a_unused_zero: assert property (s_rd(OFS_UNUSED) |-> o_rdata == 16'h0000)
    else $error("unused offset not zero");
  a_iack_status_id: assert property (!o_dtack_n && !i_iack_n && !i_strobe_n |-> o_rdata_oe && o_rdata == {8'h00, i_logical_addr})
    else $error("iack word wrong");
  a_write_no_drive: assert property (s_ack ##0 !i_write_n && i_iack_n |-> !o_rdata_oe)
    else $error("data driven on write");
  a_ack_release: assert property ($rose(i_strobe_n) |-> ##[1:5] o_dtack_n)
    else $error("ack held after strobe");
endmodule : relay_servant_checker

bind relay_servant relay_servant_checker #(.RELAYS(RELAYS)) relay_servant_checker_inst (
  .i_clk, .i_nrst, .i_addr, .i_am, .i_strobe_n, .i_write_n, .i_iack_n,
  .i_logical_addr, .o_rdata, .o_rdata_oe, .o_dtack_n, .o_relay_closed);

// *** relay_commander.sv ***
// commander model: single backplane accesses and word serial byte transfers
// assumes one clock; requests launch 1 ns after a rising edge
module relay_commander
  import relay_servant_pkg::*;
#(
  parameter logic [15:0] BASE = 16'hC600
) (
  input wire logic i_clk,
  input wire logic i_dtack_n,
  input wire logic [15:0] i_rdata,
  output logic [15:0] o_addr,
  output logic [5:0] o_am,
  output logic o_strobe_n,
  output logic o_write_n,
  output logic o_iack_n,
  output logic [15:0] o_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {o_addr, o_am, o_wdata} = '0;
    {o_strobe_n, o_write_n, o_iack_n} = 3'b111;
  end
  task automatic acc(input logic w, input logic [15:0] a, input logic [5:0] am,
      input logic [15:0] d, input logic ia, output logic [15:0] q, output logic ok);
    int n;
    @(posedge i_clk);
    #1;
    {o_addr, o_am, o_wdata, o_write_n, o_iack_n} = {a, am, d, !w, !ia};
    o_strobe_n = 1'b0;
    n = 0;
    ok = 1'b0;
    while (n < 12 && !ok) begin
      @(posedge i_clk);
      ok = (i_dtack_n === 1'b0);
      n++;
    end
    q = i_rdata;
    #1;
    o_strobe_n = 1'b1;
    n = 0;
    while (n < 12 && i_dtack_n !== 1'b1) begin
      @(posedge i_clk);
      n++;
    end
    #1;
    // released address and data lines flip so stale values cannot pass for a match
    {o_addr, o_wdata, o_write_n, o_iack_n} = {~a, ~d, 2'b11};
  endtask : acc
  task automatic reg_rd(input logic [5:0] o, output logic [15:0] q);
    logic ok;
    acc(1'b0, BASE + {10'h000, o}, ADDR_MOD_A16_SUP, 16'h0000, 1'b0, q, ok);
  endtask : reg_rd
  task automatic reg_wr(input logic [5:0] o, input logic [15:0] d);
    logic [15:0] q;
    logic ok;
    acc(1'b1, BASE + {10'h000, o}, ADDR_MOD_A16_SUP, d, 1'b0, q, ok);
  endtask : reg_wr
  task automatic poll(input int b);
    logic [15:0] q;
    int n;
    q = '0;
    n = 0;
    while (n < 30 && q[b] !== 1'b1) begin
      reg_rd(OFS_RESPONSE, q);
      n++;
    end
  endtask : poll
  task automatic send_byte(input logic [7:0] b, input logic e);
    poll(RESP_WRITE_READY_BIT);
    reg_wr(OFS_DATA_LOW_WR, {e ? WS_BYTE_AVAIL_END : WS_BYTE_AVAIL, b});
  endtask : send_byte
  task automatic get_byte(output logic [15:0] q);
    poll(RESP_WRITE_READY_BIT);
    reg_wr(OFS_DATA_LOW_WR, WS_BYTE_REQUEST);
    poll(RESP_READ_READY_BIT);
    reg_rd(OFS_DATA_LOW_RD, q);
  endtask : get_byte
  task automatic send_msg(input string s);
    for (int i = 0; i < s.len(); i++) send_byte(s[i], 1'b0);
    send_byte(CH_CR, 1'b0);
    send_byte(CH_LF, 1'b1);
  endtask : send_msg
endmodule : relay_commander

// *** relay_servant_tb_top.sv ***
// testbench for relay_servant: registers, decode, relay command messages
// assumes logical address 24, so the block sits at C600h
module relay_servant_tb_top;
  import relay_servant_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst, strobe_n, write_n, iack_n, oe, dtack_n, end_flag, ok;
  logic [15:0] addr, wdata, rdata, q;
  logic [5:0] am;
  logic [31:0] relays;
  int failures, cmp_count, cycles;
  relay_servant relay_servant_inst (.i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_am(am),
    .i_strobe_n(strobe_n), .i_write_n(write_n), .i_iack_n(iack_n), .i_wdata(wdata),
    .i_logical_addr(8'h18), .o_rdata(rdata), .o_rdata_oe(oe), .o_dtack_n(dtack_n),
    .o_relay_closed(relays), .o_end_flag(end_flag));
  relay_commander #(.BASE(16'hC600)) c (.i_clk(clk), .i_dtack_n(dtack_n), .i_rdata(rdata),
    .o_addr(addr), .o_am(am), .o_strobe_n(strobe_n), .o_write_n(write_n),
    .o_iack_n(iack_n), .o_wdata(wdata));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // a lone character reply, then the terminator with end flag on the last byte
  task automatic expect_reply(input logic [7:0] ch);
    logic [15:0] r;
    c.get_byte(r);
    chk("reply char", ch, r[7:0]);
    chk("end flag early", 1'b0, end_flag);
    c.get_byte(r);
    chk("reply cr", 8'h0D, r[7:0]);
    c.get_byte(r);
    chk("reply lf", 8'h0A, r[7:0]);
    chk("end flag", 1'b1, end_flag);
  endtask : expect_reply
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    nrst = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk("relays at reset", 32'h0, relays);
    c.reg_rd(OFS_PROTOCOL, q);
    chk("protocol", 16'hEFFF, q);
    c.reg_rd(OFS_IDENTITY, q);
    chk("identity", 16'h1234, q);
    c.reg_rd(OFS_MODEL, q);
    chk("model", 16'h5678, q);
    c.reg_rd(OFS_STATUS_CTRL, q);
    chk("status", 16'h3FF3, q & 16'hBFF3);
    c.reg_rd(OFS_RESPONSE, q);
    chk("response", 16'h4200, q & 16'hDBFF);
    c.reg_rd(OFS_UNUSED, q);
    chk("unused", 16'h0000, q);
    $display("test registers done");
    c.acc(1'b0, 16'hC608, 6'h39, 16'h0, 1'b0, q, ok);
    chk("wide space ack", 1'b0, ok);
    c.acc(1'b0, 16'hC648, ADDR_MOD_A16_SUP, 16'h0, 1'b0, q, ok);
    chk("next block ack", 1'b0, ok);
    c.acc(1'b0, 16'hC608, 6'h29, 16'h0, 1'b0, q, ok);
    chk("user space read", 17'h1EFFF, {ok, q});
    c.acc(1'b0, 16'h0000, 6'h00, 16'h0, 1'b1, q, ok);
    chk("iack word", 17'h10018, {ok, q});
    $display("test decode done");
    c.send_msg("C05");
    chk("close 5", 32'h0000_0020, relays);
    c.send_msg("C03C08C27C25");
    chk("close list", 32'h0A00_0128, relays);
    c.send_msg("C40");
    chk("out of range", 32'h0A00_0128, relays);
    c.send_msg("Q08");
    expect_reply(8'h31);
    c.send_msg("O25O08");
    chk("open 25 8", 32'h0800_0028, relays);
    c.send_msg("Q08");
    expect_reply(8'h30);
    c.reg_wr(OFS_STATUS_CTRL, 16'h7FF9);
    chk("control hold open", 32'h0, relays);
    c.send_msg("C01");
    chk("control still holds", 32'h0, relays);
    c.reg_wr(OFS_STATUS_CTRL, 16'h7FF8);
    c.send_msg("C31");
    chk("control released", 32'h8000_0000, relays);
    c.send_msg("R00");
    chk("open all", 32'h0, relays);
    $display("test relays done");
    c.poll(RESP_WRITE_READY_BIT);
    c.reg_wr(OFS_DATA_LOW_WR, WS_READ_PROTOCOL);
    c.poll(RESP_READ_READY_BIT);
    c.reg_rd(OFS_DATA_LOW_RD, q);
    chk("read protocol", 16'hFF6B, q);
    c.get_byte(q);
    chk("idle reply", 8'h0A, q[7:0]);
    chk("idle end flag", 1'b1, end_flag);
    $display("test query done");
    report_and_stop();
  end
endmodule : relay_servant_tb_top
